// ==== shared/gpt_defs.vh ====
// Constants for the two-block general-purpose timer unit.
`ifndef GPT_DEFS_VH
`define GPT_DEFS_VH
`define REG_CTRL      8'h00
`define REG_CORE      8'h04
`define REG_AUXA      8'h08
`define REG_AUXB      8'h0c
`define REG_B2CORE    8'h10
`define REG_B2TB      8'h14
`define REG_STATUS    8'h18
`define REG_IRQ_EN    8'h1c
`define REG_IRQ_CLR   8'h20
`define REG_PHASE     8'h24
`define CTRL_RUN1     0
`define CTRL_RUN2     1
`define CTRL_DOWN     2
`define CTRL_RELA     3
`define CTRL_RELB     4
`define CTRL_BLOCK_ONE_PRESCALER_LO  5
`define CTRL_BLOCK_ONE_PRESCALER_HI  6
`define CTRL_BLOCK_TWO_PRESCALER_LO  7
`define CTRL_BLOCK_TWO_PRESCALER_HI  8
`define CTRL_TIS_LO   9
`define CTRL_TIS_HI   11
`define CTRL_DOWN2    12
`define CTRL_RESET    32'h0000_0000
`define BPS_FAST      2'h1
`define TIS_FAST      3'h0
`define ST_CORE_EVT   0
`define ST_B2_EVT     1
`define ST_WIDTH      2
`endif

// ==== hdl/block_two_sequencer.v ====
// Second timer block: phase sequencer and its two timers.
`include "gpt_defs.vh"
`default_nettype none
module block_two_sequencer (
  input  wire        ref_clk_in,    // System clock.
  input  wire        rst_b_in,      // Synchronous reset, active low.
  input  wire        run_in,        // Block runs while high.
  input  wire        down_in,       // Core timer of this block counts down.
  input  wire [1:0]  bps_in,        // Block prescaler selection.
  input  wire        wr_core_in,    // Software write to the core timer.
  input  wire        wr_tb_in,      // Software write to timer b.
  input  wire [15:0] wdata_in,      // Write data.
  output reg  [15:0] core_out,      // Core timer value.
  output reg  [15:0] tb_out,        // Timer b value.
  output reg         wrap_out,      // One-cycle pulse on core wrap.
  output reg  [3:0]  phase_out      // One-hot state.
);
  // One-hot states: core timer is handled before timer b.
  localparam [3:0] S0 = 4'h1;
  localparam [3:0] S1 = 4'h2;
  localparam [3:0] S2 = 4'h4;
  localparam [3:0] S3 = 4'h8;
  wire fast = (bps_in == `BPS_FAST); // Two-state short cycle.

  // The phase walks four states, or two in the fast setting.
  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      phase_out <= S0;
      core_out  <= 16'h0000;
      tb_out    <= 16'h0000;
      wrap_out  <= 1'b0;
    end else begin
      wrap_out <= 1'b0;
      case (phase_out)
        S0: begin
          phase_out <= S1;
          if (wr_core_in) begin
            core_out <= wdata_in;
          end else if (run_in) begin
            // Core timer first, 16-bit wrap both ways.
            core_out <= down_in ? core_out - 16'h0001 : core_out + 16'h0001;
            wrap_out <= down_in ? (core_out == 16'h0000) : (core_out == 16'hffff);
          end
        end
        S1: begin
          phase_out <= fast ? S0 : S2;
          if (wr_tb_in) begin
            tb_out <= wdata_in;
          end else if (run_in && wrap_out) begin
            // Timer b counts core wraps, processed after the core.
            tb_out <= tb_out + 16'h0001;
          end
        end
        S2: begin
          phase_out <= S3;
        end
        S3: begin
          phase_out <= S0;
        end
        default: begin
          phase_out <= S0;
        end
      endcase
      // Software writes land in the cycle they arrive, so none is lost to the phase slot.
      if (wr_core_in) begin
        core_out <= wdata_in;
      end
      if (wr_tb_in) begin
        tb_out <= wdata_in;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/gpt_unit.v ====
// Two-block timer unit with sequenced processing and APB registers.
`include "gpt_defs.vh"
`default_nettype none
module gpt_unit (
  input  wire        ref_clk_in,        // System clock, 25 MHz.
  input  wire        rst_b_in,          // Synchronous reset, active low.
  input  wire        psel_in,           // APB select.
  input  wire        penable_in,        // APB enable.
  input  wire        pwrite_in,         // APB direction.
  input  wire [7:0]  paddr_in,          // APB byte address.
  input  wire [31:0] pwdata_in,         // APB write data.
  output reg  [31:0] prdata_out,        // APB read data.
  output reg         pready_out,        // APB ready.
  output reg         pslverr_out,       // APB error on unmapped address.
  output reg         irq_out,           // Level interrupt.
  output reg         core_timer_toggle_out // Toggles on each core wrap.
);
  // One-hot block-one phases.
  localparam [7:0] P0 = 8'h01;
  localparam [7:0] P1 = 8'h02;
  localparam [7:0] P2 = 8'h04;
  localparam [7:0] P3 = 8'h08;
  localparam [7:0] P4 = 8'h10;

  reg  [31:0] ctrl;           // Control register.
  reg  [15:0] core_timer;     // Block-one core timer.
  reg  [15:0] aux_timer_a;    // Reload source a.
  reg  [15:0] aux_timer_b;    // Reload source b.
  reg  [`ST_WIDTH-1:0] status; // Sticky events.
  reg  [`ST_WIDTH-1:0] irq_en; // Interrupt enables.
  reg  [7:0]  phase;          // Block-one state.
  reg         core_wrap;      // Core wrapped in this basic cycle.
  reg         late_reload;    // Aux a reload held for one basic cycle.
  wire [15:0] b2_core;
  wire [15:0] b2_tb;
  wire        b2_wrap;
  wire [3:0]  b2_phase;

  wire [1:0] block_one_prescaler     = ctrl[`CTRL_BLOCK_ONE_PRESCALER_HI:`CTRL_BLOCK_ONE_PRESCALER_LO];
  wire [1:0] block_two_prescaler     = ctrl[`CTRL_BLOCK_TWO_PRESCALER_HI:`CTRL_BLOCK_TWO_PRESCALER_LO];
  wire [2:0] core_timer_input_select = ctrl[`CTRL_TIS_HI:`CTRL_TIS_LO];
  wire       count_down = ctrl[`CTRL_DOWN];
  wire       rel_a      = ctrl[`CTRL_RELA];
  wire       rel_b      = ctrl[`CTRL_RELB];
  wire       run1       = ctrl[`CTRL_RUN1];
  // Fastest setting shortens the cycle and delays the aux a reload.
  wire fast1   = (block_one_prescaler == `BPS_FAST);
  wire fastest = fast1 && (core_timer_input_select == `TIS_FAST);

  wire acc     = psel_in && penable_in;
  wire wr      = acc && pwrite_in;
  wire wr_core = wr && (paddr_in == `REG_CORE);
  wire wr_auxa = wr && (paddr_in == `REG_AUXA);
  wire wr_auxb = wr && (paddr_in == `REG_AUXB);

  // Decodes whether an address is in the map.
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `REG_PHASE);
    end
  endfunction

  // Wrap test for a 16-bit counter in the chosen direction.
  function wraps;
    input [15:0] v;
    input        dn;
    begin
      wraps = dn ? (v == 16'h0000) : (v == 16'hffff);
    end
  endfunction

  // Block one sequencer: each timer has its own phase so interactions resolve in order.
  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      phase                 <= P0;
      core_timer            <= 16'h0000;
      aux_timer_a           <= 16'h0000;
      aux_timer_b           <= 16'h0000;
      core_wrap             <= 1'b0;
      late_reload           <= 1'b0;
      core_timer_toggle_out <= 1'b0;
    end else begin
      case (phase)
        P0: begin
          // Core timer first.
          phase     <= P1;
          core_wrap <= 1'b0;
          if (wr_core) begin
            core_timer <= pwdata_in[15:0];
          end else if (late_reload) begin
            // Delayed aux a reload lands one basic cycle late.
            core_timer  <= aux_timer_a;
            late_reload <= 1'b0;
          end else if (run1) begin
            // Counter passes through 0000/FFFF before reload.
            core_timer <= count_down ? core_timer - 16'h0001
                                     : core_timer + 16'h0001;
            if (wraps(core_timer, count_down)) begin
              core_wrap             <= 1'b1;
              core_timer_toggle_out <= ~core_timer_toggle_out;
            end
          end
        end
        P1: begin
          // Aux a: all actions except capture.
          phase <= P2;
          if (wr_auxa) begin
            aux_timer_a <= pwdata_in[15:0];
          end else if (core_wrap && rel_a) begin
            if (fastest) begin
              late_reload <= 1'b1;
            end else begin
              core_timer <= aux_timer_a;
            end
          end
        end
        P2: begin
          // Aux b after aux a; never delayed.
          phase <= fast1 ? P3 : P4;
          if (wr_auxb) begin
            aux_timer_b <= pwdata_in[15:0];
          end else if (core_wrap && rel_b && !(rel_a && !fastest)) begin
            core_timer <= aux_timer_b;
          end
        end
        P3: begin
          // Aux a capture slot, last in the cycle; closes the fast cycle.
          phase <= P0;
        end
        default: begin
          // Normal prescaling idles through the remaining states.
          phase <= (phase == 8'h80) ? P3 : {phase[6:0], 1'b0};
        end
      endcase
      // Software writes take effect at the edge the access is taken, whatever the phase.
      // Without this a master with a fixed rhythm could miss the timer's slot forever.
      if (wr_core && !pready_out) begin
        core_timer <= pwdata_in[15:0];
      end
      if (wr_auxa && !pready_out) begin
        aux_timer_a <= pwdata_in[15:0];
      end
      if (wr_auxb && !pready_out) begin
        aux_timer_b <= pwdata_in[15:0];
      end
    end
  end

  block_two_sequencer u_block_two (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .run_in     (ctrl[`CTRL_RUN2]),
    .down_in    (ctrl[`CTRL_DOWN2]),
    .bps_in     (block_two_prescaler),
    .wr_core_in (wr && (paddr_in == `REG_B2CORE)),
    .wr_tb_in   (wr && (paddr_in == `REG_B2TB)),
    .wdata_in   (pwdata_in[15:0]),
    .core_out   (b2_core),
    .tb_out     (b2_tb),
    .wrap_out   (b2_wrap),
    .phase_out  (b2_phase)
  );

  // Sticky events: a set in the clearing cycle wins.
  wire [`ST_WIDTH-1:0] ev = {b2_wrap, core_wrap && (phase == P1)};
  wire [`ST_WIDTH-1:0] clr = (wr && (paddr_in == `REG_IRQ_CLR)) ?
                             pwdata_in[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};
  wire [`ST_WIDTH-1:0] next_status = (status & ~clr) | ev;

  // APB slave: one wait state, answer in the cycle after the access phase starts.
  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ctrl        <= `CTRL_RESET;
      status      <= {`ST_WIDTH{1'b0}};
      irq_en      <= {`ST_WIDTH{1'b0}};
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      irq_out     <= 1'b0;
    end else begin
      status  <= next_status;
      irq_out <= |(next_status & irq_en);
      pready_out  <= acc && !pready_out;
      pslverr_out <= acc && !pready_out && !mapped(paddr_in);
      if (acc && !pready_out) begin
        if (pwrite_in) begin
          if (paddr_in == `REG_CTRL) begin
            ctrl <= {19'h00000, pwdata_in[12:0]};
          end
          if (paddr_in == `REG_IRQ_EN) begin
            irq_en <= pwdata_in[`ST_WIDTH-1:0];
          end
          prdata_out <= 32'h0000_0000;
        end else begin
          case (paddr_in)
            `REG_CTRL:   prdata_out <= ctrl;
            `REG_CORE:   prdata_out <= {16'h0000, core_timer};
            `REG_AUXA:   prdata_out <= {16'h0000, aux_timer_a};
            `REG_AUXB:   prdata_out <= {16'h0000, aux_timer_b};
            `REG_B2CORE: prdata_out <= {16'h0000, b2_core};
            `REG_B2TB:   prdata_out <= {16'h0000, b2_tb};
            `REG_STATUS: prdata_out <= {30'h00000000, status};
            `REG_IRQ_EN: prdata_out <= {30'h00000000, irq_en};
            `REG_PHASE:  prdata_out <= {20'h00000, b2_phase, phase};
            default:     prdata_out <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/gpt_unit_props.sv ====
// Concurrent checks on the timer unit's bus, interrupt and toggle outputs.
`default_nettype none
module gpt_unit_props (
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        irq_out,
  input wire logic        core_timer_toggle_out
);
  // All checks share the one system clock and its reset.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_ready_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready did not follow the access phase");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  chk_ready_asked: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("ready without a request");
  chk_err_unmapped: assert property (pready_out && paddr_in > 8'h24 |-> pslverr_out)
    else $error("unmapped address not refused");
  chk_err_mapped: assert property (pready_out && paddr_in <= 8'h24 && paddr_in[1:0] == 2'h0
    |-> !pslverr_out)
    else $error("mapped address refused");
  chk_err_rdata: assert property (pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
    else $error("refused read returned data");
  // One wrap per count at most, and a count lasts at least four clocks.
  chk_toggle_spacing: assert property ($changed(core_timer_toggle_out)
    |=> $stable(core_timer_toggle_out)[*3])
    else $error("toggle changed too soon");
  // The sticky level only drops after a software write.
  chk_irq_sticky: assert property ($fell(irq_out) |-> $past(psel_in && pwrite_in, 1) ||
    $past(psel_in && pwrite_in, 2) || $past(psel_in && pwrite_in, 3))
    else $error("interrupt dropped without a write");
endmodule
bind gpt_unit gpt_unit_props i_props (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .irq_out(irq_out), .core_timer_toggle_out(core_timer_toggle_out));
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the two-block timer unit.
`include "gpt_defs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;    // System clock.
  logic        rst_b = 1'b0;  // Reset, active low.
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, tog;
  int          err_count = 0, n_tests = 0;
  gpt_unit i_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .core_timer_toggle_out(tog));
  // The clock runs at 25 MHz.
  initial begin
    forever #20 clk = ~clk;
  end
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  // One APB transfer; a clock edge passes after release so calls never collide.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      finish_test;
    end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  // Timer writes land whatever the phase; still read back and retry, up to four tries.
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    int k;
    k = 0;
    do begin
      apb(1'b1, a, d, r, e);
      apb(1'b0, a, 32'h0, r, e);
      k++;
    end while (r !== d && k < 4);
    chk("write readback", r, d);
  endtask
  // Counts the clocks between two toggles of the wrap output.
  task period(input logic [31:0] c, input logic [7:0] ra, input logic [15:0] rv,
              input logic [31:0] x);
    int k;
    logic t;
    wr(`REG_CTRL, 32'h0); wr(ra, {16'h0, rv}); wr(`REG_CORE, {16'h0, rv}); wr(`REG_CTRL, c);
    repeat (2) begin
      t = tog; k = 0;
      while (tog === t && k < 500) begin
        @(posedge clk);
        k++;
      end
      if (k >= 500) begin
        err_count++;
        finish_test;
      end
    end
    chk("wrap period", k, x);
  endtask
  task sc_reset_unmapped;
    logic [31:0] r;
    logic e;
    apb(1'b0, `REG_CTRL, 32'h0, r, e);
    chk("ctrl reset", r, `CTRL_RESET);
    apb(1'b0, `REG_STATUS, 32'h0, r, e);
    chk("status reset", r, 32'h0);
    apb(1'b1, 8'h2c, 32'h5a5a_5a5a, r, e);
    chk("write refused", e, 1'b1);
    apb(1'b0, 8'h28, 32'h0, r, e);
    chk("read refused err", e, 1'b1);
    chk("read refused data", r, 32'h0);
  endtask
  task sc_phase(input logic [31:0] c, input logic [11:0] m);
    logic [31:0] r;
    logic e;
    wr(`REG_CTRL, c);
    repeat (6) begin
      apb(1'b0, `REG_PHASE, 32'h0, r, e);
      chk("b1 one state", $onehot(r[7:0]) && $onehot(r[11:8]), 1'b1);
      chk("state count", r[11:0] & ~m, 12'h0);
    end
  endtask
  task sc_transient_irq;
    logic [31:0] r;
    logic e;
    apb(1'b0, `REG_CORE, 32'h0, r, e);
    chk("core after wrap", r[15:0] >= 16'hfffd || r[15:0] <= 16'h0001, 1'b1);
    apb(1'b0, `REG_STATUS, 32'h0, r, e);
    chk("wrap status", r[0], 1'b1);
    chk("masked irq", irq, 1'b0);
    wr(`REG_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq raised", irq, 1'b1);
    wr(`REG_CTRL, 32'h0); apb(1'b1, `REG_IRQ_CLR, 32'h3, r, e);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 1'b0);
  endtask
  localparam logic [31:0] UP1 = 32'h1 << `CTRL_RUN1;
  localparam logic [31:0] F1 = {30'h0, `BPS_FAST} << `CTRL_BLOCK_ONE_PRESCALER_LO;
  localparam logic [31:0] F2 = {30'h0, `BPS_FAST} << `CTRL_BLOCK_TWO_PRESCALER_LO;
  localparam logic [31:0] RA = 32'h1 << `CTRL_RELA, RB = 32'h1 << `CTRL_RELB;
  // Main sequence: reset, then every scenario in turn.
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    sc_reset_unmapped;
    sc_phase(UP1 | 32'h2, 12'hfff);
    sc_phase(UP1 | 32'h2 | F1 | F2, 12'h30f);
    period(UP1 | RA, `REG_AUXA, 16'hfffd, 24);
    period(UP1 | RA | (32'h1 << `CTRL_DOWN), `REG_AUXA, 16'h0002, 24);
    period(UP1 | RA | F1, `REG_AUXA, 16'hfffd, 16);
    // Software compensation: a reload value one higher restores the three-count period.
    period(UP1 | RA | F1, `REG_AUXA, 16'hfffe, 12);
    period(UP1 | RB | F1, `REG_AUXB, 16'hfffd, 12);
    sc_transient_irq;
    finish_test;
  end
endmodule
`default_nettype wire
